// ==== common/light_switch_regs.svh ====
// Constants for the multiple function light switch block
`ifndef LIGHT_SWITCH_REGS_SVH
`define LIGHT_SWITCH_REGS_SVH
`define TIME_W 16
`define BLK_W 8
`define SRC_COUNT 4
`define SRC_SEL_W 2
`define TB_W 2
`define CYCLE_TIME_NS 1000
`define CLK_PERIOD_NS 40
`define CYCLE_CLKS (`CYCLE_TIME_NS / `CLK_PERIOD_NS)
`define TB_10MS 2'h0
`define TB_S 2'h1
`define TB_MIN 2'h2
`define TB_H 2'h3
`define TB_10MS_CYCLES 10
`define TB_S_CYCLES 1000
`define TB_MIN_CYCLES 60000
`define TB_H_CYCLES 3600000
`define ELAPSED_RST 16'h0000
`endif

// ==== common/light_switch_pkg.sv ====
// Types shared by the light switch block
package light_switch_pkg;
    // Switch states
    typedef enum logic [1:0] {
        SW_IDLE, SW_HOLD, SW_DELAY, SW_PERM
    } sw_state_t;
    // One timing parameter with optional indirect source
    typedef struct packed {
        logic [15:0] value;
        logic use_src;
        logic [7:0] src_block;
    } time_param_t;
    // Full configuration of the block
    typedef struct packed {
        time_param_t off_delay;
        time_param_t latch_on_hold_time;
        time_param_t warning_start_delay;
        time_param_t warning_gap_length;
        logic [1:0] timebase;
        logic warn_enable;
        logic retentive;
    } sw_cfg_t;
    // Actual value offered by another block
    typedef struct packed {
        logic [7:0] block_num;
        logic [15:0] value;
    } src_value_t;
endpackage

// ==== design/cycle_tick.sv ====
// Program cycle and timebase tick generator
`timescale 1ns/1ps
`include "light_switch_regs.svh"
module cycle_tick (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [1:0] timebase_in,
    output logic cycle_out,
    output logic unit_out
);
    import light_switch_pkg::*;
    // All state of the tick generator
    typedef struct packed {
        logic [15:0] clk_cnt;
        logic [21:0] cyc_cnt;
        logic cycle;
        logic unit;
    } tick_st_t;
    tick_st_t s_q, s_d;
    // Cycles in one timebase unit
    function automatic logic [21:0] unit_len(input logic [1:0] tb);
        case (tb)
            `TB_10MS: unit_len = 22'(`TB_10MS_CYCLES);
            `TB_S: unit_len = 22'(`TB_S_CYCLES);
            `TB_MIN: unit_len = 22'(`TB_MIN_CYCLES);
            default: unit_len = 22'(`TB_H_CYCLES);
        endcase
    endfunction
    // Next state: cycle pulse, then unit pulse counted in cycles
    always_comb begin
        s_d = s_q;
        s_d.cycle = 1'b0;
        s_d.unit = 1'b0;
        if (s_q.clk_cnt == 16'(`CYCLE_CLKS - 1)) begin
            s_d.clk_cnt = 16'h0000;
            s_d.cycle = 1'b1;
            if (s_q.cyc_cnt >= unit_len(timebase_in) - 22'h000001) begin
                s_d.cyc_cnt = 22'h000000;
                s_d.unit = 1'b1;
            end else begin
                s_d.cyc_cnt = s_q.cyc_cnt + 22'h000001;
            end
        end else begin
            s_d.clk_cnt = s_q.clk_cnt + 16'h0001;
        end
    end
    // State register
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign cycle_out = s_q.cycle;
    assign unit_out = s_q.unit;
endmodule // cycle_tick

// ==== design/param_select.sv ====
// Chooses a timing value, direct or from another block
`timescale 1ns/1ps
`include "light_switch_regs.svh"
module param_select (
    input light_switch_pkg::time_param_t param_in,
    input light_switch_pkg::src_value_t [3:0] src_in,
    output logic [15:0] value_out
);
    import light_switch_pkg::*;
    // Look up the source by block number; unknown falls back to direct
    always_comb begin
        value_out = param_in.value;
        if (param_in.use_src) begin
            for (int i = 0; i < `SRC_COUNT; i++) begin
                if (src_in[i].block_num == param_in.src_block) begin
                    value_out = src_in[i].value;
                end
            end
        end
    end
endmodule // param_select

// ==== design/light_switch.sv ====
// Multiple function light switch, evaluated once per program cycle, power loss at any clock
`timescale 1ns/1ps
`include "light_switch_regs.svh"
module light_switch (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic power_fail_in,
    input light_switch_pkg::sw_cfg_t cfg_in,
    input light_switch_pkg::src_value_t [3:0] src_in,
    output logic switch_out,
    output logic permanent_out,
    output logic [15:0] elapsed_time_out
);
    import light_switch_pkg::*;

    // All state of the switch
    typedef struct packed {
        logic [1:0] trg_sync;
        logic [1:0] clr_sync;
        logic [1:0] pf_sync;
        logic trg_prev;
        logic clr_prev;
        logic pf_prev;
        sw_state_t state;
        logic [15:0] elapsed_time;
        logic q;
        logic perm;
    } sw_st_t;
    sw_st_t s_q, s_d;

    logic cycle_tick_w; // One clock per program cycle
    logic unit_tick_w; // One clock per timebase unit
    logic [15:0] off_delay_w;
    logic [15:0] hold_w;
    logic [15:0] warn_start_w;
    logic [15:0] warn_len_w;

    // Saturating increment keeps a long hold from wrapping
    function automatic logic [15:0] inc_sat(input logic [15:0] v);
        inc_sat = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // Cycle and timebase ticks; timebase is common to all parameters
    cycle_tick u_tick (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .timebase_in(cfg_in.timebase),
        .cycle_out(cycle_tick_w),
        .unit_out(unit_tick_w)
    );

    // Parameter sources, direct or another block's actual value
    param_select u_sel_off (
        .param_in(cfg_in.off_delay),
        .src_in(src_in),
        .value_out(off_delay_w)
    );
    param_select u_sel_hold (
        .param_in(cfg_in.latch_on_hold_time),
        .src_in(src_in),
        .value_out(hold_w)
    );
    param_select u_sel_wstart (
        .param_in(cfg_in.warning_start_delay),
        .src_in(src_in),
        .value_out(warn_start_w)
    );
    param_select u_sel_wlen (
        .param_in(cfg_in.warning_gap_length),
        .src_in(src_in),
        .value_out(warn_len_w)
    );

    // Warning window: from off-delay minus start delay, for gap length
    logic [16:0] warn_begin_w;
    logic [16:0] warn_end_w;
    logic in_warn_w;
    always_comb begin
        warn_begin_w = {1'b0, off_delay_w} - {1'b0, warn_start_w};
        warn_end_w = warn_begin_w + {1'b0, warn_len_w};
        in_warn_w = 1'b0;
        if (cfg_in.warn_enable && (warn_start_w <= off_delay_w)) begin
            if (({1'b0, s_q.elapsed_time} >= warn_begin_w) &&
                ({1'b0, s_q.elapsed_time} < warn_end_w)) begin
                in_warn_w = 1'b1;
            end
        end
    end

    // Evaluation of one program cycle
    logic trg_rise_w;
    logic trg_fall_w;
    logic clr_rise_w;
    logic pf_rise_w;
    always_comb begin
        s_d = s_q;
        // Pins pass two flip-flops before anything reads them
        s_d.trg_sync = {s_q.trg_sync[0], trigger_in};
        s_d.clr_sync = {s_q.clr_sync[0], clear_in};
        s_d.pf_sync = {s_q.pf_sync[0], power_fail_in};
        trg_rise_w = s_q.trg_sync[1] && !s_q.trg_prev;
        trg_fall_w = !s_q.trg_sync[1] && s_q.trg_prev;
        clr_rise_w = s_q.clr_sync[1] && !s_q.clr_prev;
        pf_rise_w = s_q.pf_sync[1] && !s_q.pf_prev;
        if (pf_rise_w) begin
            // Power loss is seen at once, not only at a cycle boundary
            s_d.pf_prev = 1'b1;
            if (!cfg_in.retentive) begin
                s_d.state = SW_IDLE;
                s_d.elapsed_time = `ELAPSED_RST;
                s_d.q = 1'b0;
                s_d.perm = 1'b0;
            end
        end else if (cycle_tick_w) begin
            // Trigger and clear sampled only at cycle boundaries
            s_d.trg_prev = s_q.trg_sync[1];
            s_d.clr_prev = s_q.clr_sync[1];
            s_d.pf_prev = s_q.pf_sync[1];
            if (clr_rise_w || s_q.clr_sync[1]) begin
                // Clear dominates any trigger in the same cycle
                s_d.state = SW_IDLE;
                s_d.elapsed_time = `ELAPSED_RST;
                s_d.q = 1'b0;
                s_d.perm = 1'b0;
            end else begin
                case (s_q.state)
                    SW_IDLE: begin
                        if (trg_rise_w) begin
                            s_d.state = SW_HOLD;
                            s_d.q = 1'b1;
                            s_d.elapsed_time = `ELAPSED_RST;
                        end
                    end
                    SW_HOLD: begin
                        // Counting the qualification time for latch-on
                        if (trg_fall_w) begin
                            s_d.state = SW_DELAY;
                            s_d.elapsed_time = `ELAPSED_RST;
                            s_d.q = 1'b1;
                        end else if (s_q.elapsed_time >= hold_w) begin
                            s_d.state = SW_PERM;
                            s_d.perm = 1'b1;
                            s_d.q = 1'b1;
                            s_d.elapsed_time = `ELAPSED_RST;
                        end else if (unit_tick_w) begin
                            s_d.elapsed_time =
                                inc_sat(s_q.elapsed_time);
                        end
                    end
                    SW_DELAY: begin
                        if (trg_rise_w) begin
                            s_d.state = SW_IDLE;
                            s_d.elapsed_time = `ELAPSED_RST;
                            s_d.q = 1'b0;
                        end else if (s_q.elapsed_time >= off_delay_w) begin
                            s_d.state = SW_IDLE;
                            s_d.q = 1'b0;
                        end else begin
                            s_d.q = !in_warn_w;
                            if (unit_tick_w) begin
                                s_d.elapsed_time =
                                    inc_sat(s_q.elapsed_time);
                            end
                        end
                    end
                    SW_PERM: begin
                        if (trg_rise_w) begin
                            s_d.state = SW_IDLE;
                            s_d.elapsed_time = `ELAPSED_RST;
                            s_d.q = 1'b0;
                            s_d.perm = 1'b0;
                        end
                    end
                    default: begin
                        s_d.state = SW_IDLE;
                    end
                endcase
            end
        end
    end

    // State register; retentive state survives only power loss, not reset
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign switch_out = s_q.q;
    assign permanent_out = s_q.perm;
    assign elapsed_time_out = s_q.elapsed_time;
endmodule // light_switch

// ==== sim/light_switch_chk.sv ====
// Assertion checker for the light switch block, bound to its ports
`timescale 1ns/1ps
`include "light_switch_regs.svh"
module light_switch_chk (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic power_fail_in,
    input light_switch_pkg::sw_cfg_t cfg_in,
    input light_switch_pkg::src_value_t [3:0] src_in,
    input wire logic switch_out,
    input wire logic permanent_out,
    input wire logic [15:0] elapsed_time_out
);
    import light_switch_pkg::*;
    logic [15:0] clr_cnt_q; // Clocks with clear held high
    logic [15:0] clr_cnt_d;
    // Saturates so that a very long clear cannot wrap back to zero
    always_comb begin
        clr_cnt_d = clear_in ? clr_cnt_q + 16'h1 : 16'h0;
        if (clr_cnt_q == 16'hffff) begin
            clr_cnt_d = clr_cnt_q;
        end
    end
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clr_cnt_q <= 16'h0;
        end else begin
            clr_cnt_q <= clr_cnt_d;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_perm_keeps_on: assert property (permanent_out |-> switch_out)
        else $error("permanent state without output");
    a_perm_from_on: assert property ($rose(permanent_out) |->
        $past(switch_out) && elapsed_time_out == 16'h0)
        else $error("latch entered wrongly");
    a_perm_drop_off: assert property ($fell(permanent_out) |->
        !switch_out) else $error("latch left with output on");
    a_off_not_perm: assert property ($fell(switch_out) |->
        !permanent_out) else $error("output off while latched");
    // Sync latency plus one program cycle bounds the clear response
    a_clear_zeroes: assert property (clr_cnt_q > 16'(`CYCLE_CLKS + 4) |->
        !switch_out && elapsed_time_out == 16'h0)
        else $error("clear not obeyed");
    a_elapsed_step: assert property ($changed(elapsed_time_out) |->
        elapsed_time_out == 16'h0 ||
        elapsed_time_out == $past(elapsed_time_out) + 16'h1)
        else $error("elapsed time jumped");
    a_cycle_paced: assert property ($changed(elapsed_time_out) |=>
        $stable(elapsed_time_out)[*8]) else $error("elapsed changes too fast");
    a_reset_zero: assert property (disable iff (1'b0) sys_rst_in |->
        !switch_out && !permanent_out && elapsed_time_out == 16'h0)
        else $error("outputs not cleared by reset");
    c_latch: cover property ($rose(permanent_out));
    c_timeout: cover property ($fell(switch_out) && !clear_in);
    c_clear: cover property (clr_cnt_q == 16'(`CYCLE_CLKS + 5));
endmodule // light_switch_chk
bind light_switch light_switch_chk light_switch_chk_i (.ref_clk_in,
    .sys_rst_in, .trigger_in, .clear_in, .power_fail_in, .cfg_in, .src_in,
    .switch_out, .permanent_out, .elapsed_time_out);

// ==== sim/light_switch_test.sv ====
// Self-checking bench for the light switch block
`timescale 1ns/1ps
module light_switch_test;
    import light_switch_pkg::*;
    localparam int MS = 25; // Clocks in one program cycle
    logic ref_clk_in, sys_rst_in, trigger_in, clear_in, power_fail_in;
    sw_cfg_t cfg_in;
    src_value_t [3:0] src_in;
    logic switch_out, permanent_out;
    logic [15:0] elapsed_time_out;
    int bad_count = 0;
    int n_tests = 0;
    // Trigger hold, wait after release, expected switch, latch, elapsed
    typedef struct { int h; int w; logic s; logic p; logic [15:0] e; } row_t;
    row_t rows [4] = '{'{10, 15, 1, 0, 16'h1}, '{10, 45, 0, 0, 16'hffff},
        '{65, 5, 1, 1, 16'hffff}, '{65, 40, 1, 1, 16'hffff}};
    light_switch light_switch_i (.ref_clk_in, .sys_rst_in, .trigger_in,
        .clear_in, .power_fail_in, .cfg_in, .src_in, .switch_out,
        .permanent_out, .elapsed_time_out);
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // Waits whole program cycles, then steps off the edge
    task automatic ms(input int n);
        repeat (n * MS) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic out(input logic s, input logic p);
        check("switch", {15'h0, switch_out}, {15'h0, s});
        check("permanent", {15'h0, permanent_out}, {15'h0, p});
    endtask
    task automatic pulse(input int n);
        trigger_in = 1'b1;
        ms(n);
        trigger_in = 1'b0;
    endtask
    // Clear first so the case that follows starts from the off state
    task automatic idle;
        clear_in = 1'b1;
        ms(3);
        clear_in = 1'b0;
        ms(2);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        sys_rst_in = 1'b1;
        trigger_in = 1'b0;
        clear_in = 1'b0;
        power_fail_in = 1'b0;
        src_in = '0;
        cfg_in = '0;
        cfg_in.timebase = 2'h0;
        cfg_in.off_delay.value = 16'h0003;
        cfg_in.latch_on_hold_time.value = 16'h0005;
        cfg_in.warning_start_delay.value = 16'h0002;
        cfg_in.warning_gap_length.value = 16'h0001;
        repeat (6) @(posedge ref_clk_in);
        #1;
        out(1'b0, 1'b0);
        sys_rst_in = 1'b0;
        foreach (rows[i]) begin
            idle;
            pulse(rows[i].h);
            ms(rows[i].w);
            out(rows[i].s, rows[i].p);
            if (rows[i].e != 16'hffff)
                check("elapsed", elapsed_time_out, rows[i].e);
        end
        pulse(5);
        ms(5);
        out(1'b0, 1'b0);
        pulse(5);
        ms(5);
        pulse(5);
        ms(5);
        out(1'b0, 1'b0);
        idle;
        trigger_in = 1'b1;
        ms(25);
        check("hold time", elapsed_time_out, 16'h2);
        trigger_in = 1'b0;
        ms(5);
        clear_in = 1'b1;
        ms(3);
        out(1'b0, 1'b0);
        check("elapsed", elapsed_time_out, 16'h0);
        cfg_in.warn_enable = 1'b1;
        idle;
        pulse(5);
        ms(15);
        out(1'b0, 1'b0);
        ms(10);
        out(1'b1, 1'b0);
        ms(20);
        out(1'b0, 1'b0);
        cfg_in.warn_enable = 1'b0;
        for (int r = 0; r < 2; r++) begin
            cfg_in.retentive = r[0];
            idle;
            pulse(5);
            power_fail_in = 1'b1;
            ms(3);
            power_fail_in = 1'b0;
            out(r[0], 1'b0);
        end
        cfg_in.retentive = 1'b0;
        src_in[2] = '{block_num: 8'h05, value: 16'h0001};
        cfg_in.off_delay.use_src = 1'b1;
        cfg_in.off_delay.src_block = 8'h05;
        idle;
        pulse(5);
        ms(15);
        out(1'b0, 1'b0);
        final_report;
    end
    // Cuts a hang short, well past the expected run length
    initial begin
        repeat (900 * MS) @(posedge ref_clk_in);
        bad_count++;
        final_report;
    end
endmodule // light_switch_test
